// *** shared/irq_gate_pkg.sv ***
// package: offsets, field positions and reset values of the block interrupt enable gate
// Behaviour
// RL1: bit 7 gates national-bit block requests; 0 blocks them from the interrupt output.
// RL2: a set block enable alone never raises the interrupt; a source request is needed.
// RL3: bit 5 enables the recovered clock loss request; 0 suppresses it.
// RL4: bit 4 enables the one-second tick request; 0 means it is never raised.
// RL5: bit 3 gates all datalink controller requests at block level.
// RL6: bit 2 gates all elastic store requests at block level.
// RL7: bit 1 gates all alarm and error requests at block level.
// RL8: bit 0 gates all framer block requests at block level.
// RL9: each status flag sits at its enable bit position and shows a pending request.
// RL10: a status flag clears once the source status register has been read.
// RL11: interrupt is high while any pending request has its block enable set.
package irq_gate_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [11:0] BLOCK_INTERRUPT_STATUS_IDX = 12'hB00;
	localparam logic [11:0] BLOCK_INTERRUPT_ENABLE_IDX = 12'hB01;
	localparam int unsigned ADDR_W = 14;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = {BLOCK_INTERRUPT_STATUS_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] ENABLE_ADDR = {BLOCK_INTERRUPT_ENABLE_IDX, 2'b00};
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// bit 6 is reserved in this mode
	localparam logic [7:0] ENABLE_WMASK = 8'hBF;
	localparam int unsigned NATIONAL_BIT_POS = 7;
	localparam int unsigned CLOCK_LOSS_POS = 5;
	localparam int unsigned ONE_SECOND_POS = 4;
	localparam int unsigned DATALINK_POS = 3;
	localparam int unsigned ELASTIC_STORE_POS = 2;
	localparam int unsigned ALARM_ERROR_POS = 1;
	localparam int unsigned FRAMER_POS = 0;
	localparam int unsigned NUM_SRC = 8;

	// per-block request lines and source-status read strobes
	typedef struct packed {
		logic [NUM_SRC-1:0] raise;
		logic [NUM_SRC-1:0] src_read;
	} source_events_s;

	// classic wishbone request
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [ADDR_W-1:0] adr;
		logic [31:0] dat;
	} wb_req_s;
endpackage : irq_gate_pkg

// *** rtl/block_pending_flag.sv ***
// one block-level pending flag: set by source request, cleared by source status read
`timescale 1ns/1ps
module block_pending_flag (
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic NRST_I,
	// events
	input wire logic RAISE_I,
	input wire logic SRC_READ_I,
	// state
	output logic PENDING_O
);
	import irq_gate_pkg::*;
	logic pending_q;

	// set wins over a read in the same cycle so a fresh request is not lost
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			pending_q <= 1'b0;
		end else if (RAISE_I) begin
			pending_q <= 1'b1; // [RL9]
		end else if (SRC_READ_I) begin
			pending_q <= 1'b0; // [RL10]
		end
	end

	assign PENDING_O = pending_q;
endmodule : block_pending_flag

// *** rtl/block_interrupt_enable_gate.sv ***
// block-level interrupt enable register, pending flags and gated interrupt output
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module block_interrupt_enable_gate (
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic NRST_I,
	// wishbone slave
	input wire irq_gate_pkg::wb_req_s WB_REQ_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// source side
	input wire irq_gate_pkg::source_events_s SRC_I,
	// interrupt
	output logic IRQ_O
);
	import irq_gate_pkg::*;

	// ack is the whole of the answer state, so it stands exactly one cycle
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} bus_state_e;

	bus_state_e bus_state_q;
	bus_state_e bus_state_d;
	logic [7:0] block_interrupt_enable_q;
	logic [7:0] block_interrupt_enable_d;
	wire logic [7:0] block_interrupt_status;
	wire logic [7:0] gated_raise;
	wire logic [7:0] gated_request;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic irq_q;
	logic irq_d;
	logic request;
	logic access;
	logic commit;
	logic enable_write;
	logic hit_enable;
	logic hit_status;

	// a request is taken only while no answer is out, so a held request is not served twice
	assign request = WB_REQ_I.cyc && WB_REQ_I.stb;
	assign access = request && (bus_state_q == BUS_IDLE);
	// a write lands at the edge where the master sees ack high, not earlier
	assign commit = request && (bus_state_q == BUS_ACK);
	assign hit_enable = (WB_REQ_I.adr == ENABLE_ADDR);
	assign hit_status = (WB_REQ_I.adr == STATUS_ADDR);
	// only byte lane 0 carries the register
	assign enable_write = commit && WB_REQ_I.we && hit_enable && WB_REQ_I.sel[0];

	always_comb begin
		bus_state_d = bus_state_q;
		case (bus_state_q)
			BUS_IDLE: begin
				if (access) begin
					bus_state_d = BUS_ACK;
				end
			end
			BUS_ACK: begin
				bus_state_d = BUS_IDLE;
			end
			default: begin
				bus_state_d = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			bus_state_q <= BUS_IDLE;
		end else begin
			bus_state_q <= bus_state_d;
		end
	end

	// read data is latched when the request is taken and stands until the next read
	// unmapped addresses read as zero but are still answered
	always_comb begin
		rdata_d = rdata_q;
		if (access && !WB_REQ_I.we) begin
			if (hit_enable) begin
				rdata_d = {24'h000000, block_interrupt_enable_q};
			end else if (hit_status) begin
				rdata_d = {24'h000000, block_interrupt_status}; // [RL9]
			end else begin
				rdata_d = 32'h00000000;
			end
		end
	end

	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	for (genvar b = 0; b < NUM_SRC; b++) begin : g_bit
		// reserved bit stays zero whatever software writes
		assign block_interrupt_enable_d[b] = enable_write ? (WB_REQ_I.dat[b] & ENABLE_WMASK[b])
			: block_interrupt_enable_q[b];
		// clock loss and one-second enables act at the source: a disabled event never sets its flag
		if (b == CLOCK_LOSS_POS || b == ONE_SECOND_POS) begin : g_source_level // [RL3] [RL4]
			assign gated_raise[b] = SRC_I.raise[b] & block_interrupt_enable_q[b];
		end else begin : g_block_level
			// except for reserved bit 6, which never sets, the flag sets while the block is disabled, so the pin follows once it is enabled
			assign gated_raise[b] = SRC_I.raise[b] & ENABLE_WMASK[b];
		end
		block_pending_flag u_flag (
			.REF_CLK_I(REF_CLK_I),
			.NRST_I(NRST_I),
			.RAISE_I(gated_raise[b]),
			.SRC_READ_I(SRC_I.src_read[b]),
			.PENDING_O(block_interrupt_status[b])
		);
		// a set enable alone never asserts: a pending flag is needed as well
		assign gated_request[b] = block_interrupt_status[b] & block_interrupt_enable_q[b]; // [RL1] [RL2] [RL5] [RL6] [RL7] [RL8]
	end

	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			block_interrupt_enable_q <= ENABLE_RESET;
		end else begin
			block_interrupt_enable_q <= block_interrupt_enable_d;
		end
	end

	// registered so the pin is glitch free; costs one cycle of latency
	assign irq_d = |gated_request; // [RL11]

	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign WB_ACK_O = (bus_state_q == BUS_ACK);
	assign WB_DAT_O = rdata_q;
	assign IRQ_O = irq_q;
endmodule : block_interrupt_enable_gate

// *** tb/gate_checker.sv ***
// port checker for the interrupt gate
`timescale 1ns/1ps
module gate_checker import irq_gate_pkg::*; (
	input wire logic REF_CLK_I,
	input wire logic NRST_I,
	input wire wb_req_s WB_REQ_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire source_events_s SRC_I,
	input wire logic IRQ_O
);
	logic [7:0] st_q;
	logic [7:0] en_q;
	wire rq = WB_REQ_I.cyc && WB_REQ_I.stb && !WB_ACK_O;
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!NRST_I);
	// superset of pending flags: enables are not tracked, so only upper bounds hold
	always_ff @(posedge REF_CLK_I or negedge NRST_I)
		if (!NRST_I) st_q <= 8'h00;
		else st_q <= st_q & ~SRC_I.src_read | SRC_I.raise & 8'hBF;
	// mirror of the enable register, loaded at the edge where the master sees ack
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			en_q <= 8'h00;
		end else if (WB_REQ_I.cyc && WB_REQ_I.stb && WB_REQ_I.we && WB_ACK_O && WB_REQ_I.sel[0]
			&& WB_REQ_I.adr == ENABLE_ADDR) begin
			en_q <= WB_REQ_I.dat[7:0] & 8'hBF;
		end
	end
	a_ack_pulse: assert property (rq |=> WB_ACK_O ##1 !WB_ACK_O) else $error("ack");
	a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(rq)) else $error("ack");
	a_dat_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0) else $error("dat");
	a_irq_cause: assert property (IRQ_O |-> $past(|st_q)) else $error("irq");
	a_read_clears: assert property (SRC_I.raise == 8'h00 && SRC_I.src_read == st_q |=> ##1 !IRQ_O)
		else $error("irq");
	a_irq_gated: assert property (IRQ_O |-> $past(|(st_q & en_q))) else $error("irq");
	a_ack_idle: assert property (!WB_REQ_I.cyc |=> !WB_ACK_O) else $error("ack");
endmodule : gate_checker
bind block_interrupt_enable_gate gate_checker u_chk (.REF_CLK_I, .NRST_I, .WB_REQ_I, .WB_DAT_O, .WB_ACK_O, .SRC_I, .IRQ_O);

// *** tb/block_interrupt_enable_gate_tb.sv ***
// bench for the interrupt gate
`timescale 1ns/1ps
module block_interrupt_enable_gate_tb;
	import irq_gate_pkg::*;
	logic clk = 0, nrst = 0, ack, irq;
	logic [31:0] dat;
	logic [7:0] q[$], e, b;
	wb_req_s rq = '0;
	source_events_s sr = '0;
	int fails = 0, checks = 0, n = 0;
	block_interrupt_enable_gate dut (.REF_CLK_I(clk), .NRST_I(nrst), .WB_REQ_I(rq), .WB_DAT_O(dat), .WB_ACK_O(ack),
		.SRC_I(sr), .IRQ_O(irq));
	initial forever #10 clk = ~clk;
	task automatic chk(input logic [7:0] x, input logic [31:0] g);
		checks++;
		if (g !== {24'h0, x}) fails++;
		if (g !== {24'h0, x}) $display("MISMATCH %0t %h %h", $time, x, g);
	endtask : chk
	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : report_and_stop
	// on a read, d is the expected value; the slave ignores write data then
	task automatic wb(input logic w, input logic [13:0] a, input logic [7:0] d);
		@(posedge clk);
		rq <= '{1'b1, 1'b1, w, 4'hF, a, {24'h0, d}};
		if (!w) q.push_back(d);
		do @(posedge clk); while (ack !== 1'b1);
		rq <= '0;
	endtask : wb
	task automatic ev(input logic [7:0] r, input logic [7:0] c, input logic x);
		@(posedge clk);
		sr <= '{r, c};
		@(posedge clk);
		sr <= '0;
		repeat (3) @(posedge clk);
		chk({7'h0, x}, {31'h0, irq});
	endtask : ev
	always @(posedge clk) begin
		if (ack === 1'b1 && !rq.we) chk(q.pop_front(), dat);
		if (++n == 2000) fails++;
		if (n == 2000) report_and_stop();
	end
	initial begin
		void'($urandom(32'h28aee4a5));
		repeat (3) @(posedge clk);
		nrst <= 1;
		e = 8'($urandom);
		wb(0, ENABLE_ADDR, ENABLE_RESET);
		wb(0, STATUS_ADDR, STATUS_RESET);
		wb(1, ENABLE_ADDR, e);
		wb(0, ENABLE_ADDR, e & ENABLE_WMASK);
		for (int i = 0; i < 8; i++) begin
			b = 8'h01 << i;
			wb(1, ENABLE_ADDR, 8'h00);
			ev(b, 0, 0);
			wb(0, STATUS_ADDR, i inside {4, 5, 6} ? 8'h00 : b);
			wb(1, ENABLE_ADDR, b);
			ev(0, 0, !(i inside {4, 5, 6}));
			ev(b, 0, i != 6);
			ev(0, b, 0);
			wb(0, STATUS_ADDR, 8'h00);
		end
		wb(0, 14'h0008, 8'h00);
		@(posedge clk);
		report_and_stop();
	end
endmodule : block_interrupt_enable_gate_tb
